// ### common/scs_pkg.sv
// Shared constants, types and carriers of the safety switch channel logic.
// Assumes a single 10 MHz clock and an AHB-Lite register bus.
package scs_pkg;

    // Register byte offsets
    localparam logic [7:0] SCS_A_CTRL = 8'h00;
    localparam logic [7:0] SCS_A_STATUS = 8'h04;
    localparam logic [7:0] SCS_A_SERIAL = 8'h08;
    localparam logic [7:0] SCS_A_TEACH = 8'h0C;
    localparam logic [7:0] SCS_A_NAME = 8'h10;

    // Field positions and reset values
    localparam int SCS_CTRL_DIAG_EN_BIT = 0;
    localparam logic SCS_CTRL_DIAG_EN_RST = 1'b1;

    // Diagnostic memory slots
    localparam logic [1:0] SCS_M_SERIAL = 2'h0;
    localparam logic [1:0] SCS_M_TEACH = 2'h1;
    localparam logic [1:0] SCS_M_NAME = 2'h2;

    // Diagnostic request codes
    localparam logic [3:0] SCS_CMD_STATUS = 4'h0;
    localparam logic [3:0] SCS_CMD_SERIAL = 4'h1;
    localparam logic [3:0] SCS_CMD_CONFIG = 4'h2;
    localparam logic [3:0] SCS_CMD_ACTION = 4'h3;

    // Timing
    localparam int SCS_CLK_NS = 100;
    localparam int SCS_FILT_NS = 300;
    localparam int SCS_FILT_CYC = (SCS_FILT_NS + SCS_CLK_NS - 1) / SCS_CLK_NS;
    localparam int SCS_BIT_NS = 1000;
    localparam int SCS_BIT_CYC = (SCS_BIT_NS + SCS_CLK_NS - 1) / SCS_CLK_NS;
    localparam int SCS_CMD_BITS = 4;
    localparam int SCS_REPLY_BITS = 18;

    typedef enum logic [1:0] {
        SCS_NORMAL = 2'b00,
        SCS_UNEQUAL = 2'b01,
        SCS_LOCK = 2'b10
    } scs_plaus_t;

    typedef enum logic [2:0] {
        SCS_D_IDLE = 3'b000,
        SCS_D_RX = 3'b001,
        SCS_D_FETCH = 3'b010,
        SCS_D_WAIT = 3'b011,
        SCS_D_TX = 3'b100
    } scs_diag_t;

    typedef enum logic [1:0] {
        SCS_IN_OFF = 2'b00,
        SCS_IN_ON = 2'b01,
        SCS_IN_QUICK = 2'b10,
        SCS_IN_FLASH = 2'b11
    } scs_in_ind_t;

    typedef enum logic [1:0] {
        SCS_DEV_GREEN = 2'b00,
        SCS_DEV_RED_FLASH = 2'b01
    } scs_dev_ind_t;

    typedef struct packed {
        logic ch2;
        logic ch1;
    } scs_chan_t;

    typedef struct packed {
        scs_in_ind_t input_indicator;
        scs_dev_ind_t device_indicator;
    } scs_ind_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } scs_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } scs_ahb_rsp_t;

endpackage : scs_pkg

// ### hdl/scs_mem.sv
// Small word store for the answers given over the diagnostic link.
// Assumes one writer and one reader; read data appear one enabled edge later.
module scs_mem #(
    parameter int W = 16,
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // Write port
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [W-1:0] i_wdata,
    // Read port
    input wire logic [AW-1:0] i_raddr,
    output logic [W-1:0] o_rdata
);
    import scs_pkg::*;

    if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_chk
        $error("scs_mem: DEPTH does not fit AW");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [W-1:0] rd;
    } scs_mem_st_t;

    scs_mem_st_t q;
    scs_mem_st_t d;

    always_comb begin
        d = q;
        if (i_we && 32'(i_waddr) < DEPTH) begin
            d.mem[i_waddr] = i_wdata;
        end
        d.rd = (32'(i_raddr) < DEPTH) ? q.mem[i_raddr] : '0;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_rdata = q.rd;

endmodule : scs_mem

// ### hdl/scs_top.sv
// Output decision, plausibility check and diagnostic link of the switch.
// Assumes inputs synchronous to i_clk and a single AHB-Lite master.
// Function
// - With actuator present each safety output follows its own safety input.
// - Without actuator both safety outputs are low regardless of inputs.
// - Without diagnostics the signal output shows actuator presence.
// - One input falling while other stays high enters unequal indication.
// - Fallen input returning high while other high locks that channel.
// - Lock ends, and rising accepted again, only after both inputs low.
// - With a diagnostic module attached the diagnostic input is read.
// - Without a diagnostic module the diagnostic input is ignored.
// - In diagnostic mode the signal output carries reply data.
// - Diagnostic link comes up again on every power-up automatically.
// - The serial number is reported over the diagnostic link.
// - Status requests return switching state and open circuit hint.
// - Configuration requests return remaining teach-in count.
// - Action requests refresh and return the actuator name.
// - Diagnostics never alter the safety input to output behaviour.
module scs_top #(
    parameter int FILT_CYC = scs_pkg::SCS_FILT_CYC,
    parameter int BIT_CYC = scs_pkg::SCS_BIT_CYC
) (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // Safety channel
    input wire scs_pkg::scs_chan_t i_safety_in,
    input wire logic i_actuator_present,
    output scs_pkg::scs_chan_t o_safety_out,
    // Diagnostic link and signal output
    input wire logic i_diag_in,
    output logic o_signal_diag_out,
    // Indicators
    output scs_pkg::scs_ind_t o_ind,
    // Register bus
    input wire scs_pkg::scs_ahb_req_t i_ahb,
    output scs_pkg::scs_ahb_rsp_t o_ahb
);
    import scs_pkg::*;

    localparam int FW = $clog2(FILT_CYC + 1);
    localparam int BW = $clog2(2 * BIT_CYC + 1);

    if (FILT_CYC < 1 || BIT_CYC < 2) begin : g_chk
        $error("scs_top: FILT_CYC must be >= 1 and BIT_CYC >= 2");
    end

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] filt;
        logic [1:0][FW-1:0] cnt;
        logic act;
        scs_plaus_t plaus;
        logic [1:0] fell;
        logic [1:0] out;
        scs_in_ind_t in_ind;
        scs_dev_ind_t dev_ind;
        logic seen;
        logic present;
        logic ctrl_en;
        logic dmode;
        scs_diag_t dstate;
        logic [BW-1:0] tim;
        logic [4:0] bitn;
        logic [3:0] cmd;
        logic [SCS_REPLY_BITS-1:0] shreg;
        logic [7:0] refresh;
        logic sig;
        logic a_valid;
        logic a_wr;
        logic [7:0] a_addr;
        logic [31:0] hrdata;
        logic hreadyout;
    } scs_st_t;

    scs_st_t q;
    scs_st_t d;

    logic ap;
    logic [1:0] nf;
    logic [1:0] lockmask;
    logic [15:0] stat16;
    logic [15:0] word;
    logic [15:0] mem_rd;
    logic mem_we;
    logic [1:0] mem_waddr;
    logic [1:0] mem_raddr;

    // Diagnostic status word, shared by bus and link
    assign stat16 = {6'h00, q.act & ~(|q.filt), q.present, q.dmode,
                     q.plaus == SCS_LOCK, q.plaus == SCS_UNEQUAL,
                     q.out, q.filt, q.act};

    // Bus writes to the answer store happen in the data phase
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = SCS_M_SERIAL;
        if (q.a_valid && q.a_wr) begin
            case (q.a_addr)
                SCS_A_SERIAL: begin
                    mem_we = 1'b1;
                    mem_waddr = SCS_M_SERIAL;
                end
                SCS_A_TEACH: begin
                    mem_we = 1'b1;
                    mem_waddr = SCS_M_TEACH;
                end
                SCS_A_NAME: begin
                    mem_we = 1'b1;
                    mem_waddr = SCS_M_NAME;
                end
                default: mem_we = 1'b0;
            endcase
        end
    end

    always_comb begin
        case (q.cmd)
            SCS_CMD_SERIAL: mem_raddr = SCS_M_SERIAL;
            SCS_CMD_CONFIG: mem_raddr = SCS_M_TEACH;
            SCS_CMD_ACTION: mem_raddr = SCS_M_NAME;
            default: mem_raddr = SCS_M_SERIAL;
        endcase
    end

    scs_mem #(
        .W(16),
        .DEPTH(3),
        .AW(2)
    ) u_mem (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(i_ahb.hwdata[15:0]),
        .i_raddr(mem_raddr),
        .o_rdata(mem_rd)
    );

    always_comb begin
        d = q;
        word = stat16;
        ap = i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready;

        // First stage feeds only the second stage
        d.sync1 = {i_safety_in.ch2, i_safety_in.ch1};
        d.sync2 = q.sync1;
        d.act = i_actuator_present;
        // A level must persist FILT_CYC cycles to be believed
        for (int c = 0; c < 2; c++) begin
            if (q.sync2[c] == q.filt[c]) begin
                d.cnt[c] = '0;
            end else if (q.cnt[c] == FW'(FILT_CYC - 1)) begin
                d.filt[c] = q.sync2[c];
                d.cnt[c] = '0;
            end else begin
                d.cnt[c] = q.cnt[c] + FW'(1);
            end
        end
        nf = d.filt;

        // Plausibility tracking, blind to the diagnostic side
        case (q.plaus)
            SCS_NORMAL: begin
                if (q.filt == 2'b11 && (nf == 2'b01 || nf == 2'b10)) begin
                    d.plaus = SCS_UNEQUAL;
                    d.fell = ~nf;
                end
            end
            SCS_UNEQUAL: begin
                if (nf == 2'b00) begin
                    d.plaus = SCS_NORMAL;
                end else if (nf == 2'b11) begin
                    d.plaus = SCS_LOCK;
                end
            end
            SCS_LOCK: begin
                if (nf == 2'b00) begin
                    d.plaus = SCS_NORMAL;
                end
            end
            default: d.plaus = SCS_NORMAL;
        endcase
        // Only the channel that re-rose is held off; the other keeps working
        lockmask = (d.plaus == SCS_LOCK) ? d.fell : 2'b00;
        d.out = d.act ? (nf & ~lockmask) : 2'b00;

        case (d.plaus)
            SCS_UNEQUAL: d.in_ind = SCS_IN_QUICK;
            SCS_LOCK: d.in_ind = SCS_IN_FLASH;
            default: d.in_ind = (nf != 2'b00) ? SCS_IN_ON : SCS_IN_OFF;
        endcase
        d.dev_ind = (d.plaus == SCS_NORMAL) ? SCS_DEV_GREEN
                                            : SCS_DEV_RED_FLASH;

        // Module presence is judged once per power-up from the idle line
        if (!q.seen) begin
            d.seen = 1'b1;
            d.present = i_diag_in;
        end

        // Register bus: capture address phase, act in data phase
        d.hreadyout = 1'b1;
        d.a_valid = ap;
        d.a_wr = ap && i_ahb.hwrite;
        d.a_addr = i_ahb.haddr[7:0];
        if (ap && !i_ahb.hwrite) begin
            case (i_ahb.haddr[7:0])
                SCS_A_CTRL: d.hrdata = {31'h0, q.ctrl_en};
                SCS_A_STATUS: d.hrdata = {8'h00, q.refresh, stat16};
                default: d.hrdata = 32'h0000_0000;
            endcase
        end
        if (q.a_valid && q.a_wr && q.a_addr == SCS_A_CTRL) begin
            d.ctrl_en = i_ahb.hwdata[SCS_CTRL_DIAG_EN_BIT];
        end
        d.dmode = d.present && d.ctrl_en;

        // Diagnostic engine: 4-bit request in, 16-bit reply out, LSB first
        case (q.dstate)
            SCS_D_IDLE: begin
                if (q.dmode && !i_diag_in) begin
                    d.dstate = SCS_D_RX;
                    d.tim = BW'(BIT_CYC + BIT_CYC / 2 - 1);
                    d.bitn = 5'h00;
                end
            end
            SCS_D_RX: begin
                if (q.tim != '0) begin
                    d.tim = q.tim - BW'(1);
                end else begin
                    d.cmd = {i_diag_in, q.cmd[3:1]};
                    d.tim = BW'(BIT_CYC - 1);
                    if (q.bitn == 5'(SCS_CMD_BITS - 1)) begin
                        d.dstate = SCS_D_FETCH;
                    end else begin
                        d.bitn = q.bitn + 5'h01;
                    end
                end
            end
            SCS_D_FETCH: d.dstate = SCS_D_WAIT;
            SCS_D_WAIT: begin
                case (q.cmd)
                    SCS_CMD_SERIAL: word = mem_rd;
                    SCS_CMD_CONFIG: word = mem_rd;
                    SCS_CMD_ACTION: begin
                        word = mem_rd;
                        d.refresh = q.refresh + 8'h01;
                    end
                    default: word = stat16;
                endcase
                d.shreg = {1'b1, word, 1'b0};
                d.dstate = SCS_D_TX;
                d.tim = BW'(BIT_CYC - 1);
                d.bitn = 5'h00;
            end
            SCS_D_TX: begin
                if (q.tim != '0) begin
                    d.tim = q.tim - BW'(1);
                end else begin
                    d.shreg = {1'b1, q.shreg[SCS_REPLY_BITS-1:1]};
                    d.tim = BW'(BIT_CYC - 1);
                    if (q.bitn == 5'(SCS_REPLY_BITS - 1)) begin
                        d.dstate = SCS_D_IDLE;
                    end else begin
                        d.bitn = q.bitn + 5'h01;
                    end
                end
            end
            default: d.dstate = SCS_D_IDLE;
        endcase
        if (!d.dmode) begin
            d.dstate = SCS_D_IDLE;
        end

        if (d.dmode) begin
            d.sig = (d.dstate == SCS_D_TX) ? d.shreg[0] : 1'b1;
        end else begin
            d.sig = d.act;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
            q.plaus <= SCS_NORMAL;
            q.dstate <= SCS_D_IDLE;
            q.ctrl_en <= SCS_CTRL_DIAG_EN_RST;
            q.hreadyout <= 1'b1;
            q.shreg <= '1;
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_safety_out = {q.out[1], q.out[0]};
    assign o_signal_diag_out = q.sig;
    assign o_ind = {q.in_ind, q.dev_ind};
    assign o_ahb = {q.hrdata, q.hreadyout, 1'b0};

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_fetch_wait;
        (q.dstate == SCS_D_FETCH) && i_ce ##1 (q.dstate == SCS_D_WAIT);
    endsequence

    a_follow_in: assert property (
        q.act && q.plaus == SCS_NORMAL |-> q.out == q.filt)
        else $error("safety outputs do not follow inputs");
    a_absent_low: assert property (
        !q.act |-> q.out == 2'b00)
        else $error("safety output high without actuator");
    a_sig_presence: assert property (
        !q.dmode |-> o_signal_diag_out == q.act)
        else $error("signal output does not show presence");
    a_unequal_entry: assert property (
        $rose(q.plaus == SCS_UNEQUAL) |->
            $past(q.filt) == 2'b11 && q.filt != 2'b00 &&
            o_ind.input_indicator == SCS_IN_QUICK)
        else $error("unequal state entered without cause");
    a_lock_entry: assert property (
        $rose(q.plaus == SCS_LOCK) |->
            q.filt == 2'b11 && $past(q.plaus) == SCS_UNEQUAL &&
            (q.out & q.fell) == 2'b00)
        else $error("lock entered wrongly or channel not held");
    a_lock_exit: assert property (
        $fell(q.plaus == SCS_LOCK) |-> q.filt == 2'b00)
        else $error("lock left without both inputs low");
    a_diag_ignore: assert property (
        !q.dmode |-> q.dstate == SCS_D_IDLE)
        else $error("diagnostic engine active without module");
    a_tx_line: assert property (
        q.dstate == SCS_D_TX |-> o_signal_diag_out == q.shreg[0])
        else $error("signal output not carrying reply");
    a_reply_start: assert property (
        s_fetch_wait ##0 (i_ce && d.dmode) |=>
            q.dstate == SCS_D_TX && !o_signal_diag_out)
        else $error("reply did not start with start bit");
    a_serial_reply: assert property (
        q.dstate == SCS_D_WAIT && q.cmd == SCS_CMD_SERIAL && i_ce &&
        d.dmode |=> q.shreg[16:1] == $past(mem_rd))
        else $error("serial reply does not match store");
    a_filter_path: assert property (
        ((q.filt ^ $past(q.filt)) & (q.filt ^ $past(q.sync2))) == 2'b00)
        else $error("filtered input changed without synced level");

endmodule : scs_top

// ### verif/safety_switch_channel_logic_tb_top.sv
// Self-checking bench of the safety switch channel logic.
// Assumes scs_diag_partner on the diagnostic lines and default counts.
module safety_switch_channel_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import scs_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic act = 1'b0;
    logic attached = 1'b0;
    logic noise = 1'b0;
    logic ce = 1'b1;
    scs_chan_t sin = '0;
    scs_chan_t sout;
    logic sig_out;
    logic diag_line;
    scs_ind_t ind;
    logic m_sel = 1'b0;
    logic m_write = 1'b0;
    logic [1:0] m_trans = 2'h0;
    logic [31:0] m_addr = '0;
    logic [31:0] m_wdata = '0;
    scs_ahb_req_t req;
    scs_ahb_rsp_t rsp;
    int n_errors = 0;
    int num_checks = 0;
    logic [31:0] seed = 32'hF8857EAB;
    assign req = {m_sel, m_addr, m_trans, m_write, 3'h2, m_wdata,
                  rsp.hreadyout};
    scs_top i_scs_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
        .i_safety_in(sin), .i_actuator_present(act), .o_safety_out(sout),
        .i_diag_in(diag_line), .o_signal_diag_out(sig_out), .o_ind(ind),
        .i_ahb(req), .o_ahb(rsp));
    scs_diag_partner #(.BIT_CYC(SCS_BIT_CYC)) i_scs_diag_partner (
        .i_clk(i_clk), .i_attached(attached), .i_noise(noise),
        .i_tx_line(sig_out), .o_rx_line(diag_line));
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [1:0] exp_out(logic a, logic [1:0] s);
        return a ? s : 2'b00;
    endfunction : exp_out
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time,
                     what, seen, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge i_clk);
        m_sel <= 1'b1;
        m_addr <= {24'h0, a};
        m_trans <= 2'h2;
        m_write <= wr;
        do @(posedge i_clk); while (rsp.hreadyout !== 1'b1);
        m_sel <= 1'b0;
        m_trans <= 2'h0;
        m_wdata <= wd;
        do @(posedge i_clk); while (rsp.hreadyout !== 1'b1);
        rd = rsp.hrdata;
    endtask : bus
    // Waits past sync and filter so every check sees settled outputs
    task automatic drive(input logic a, input logic [1:0] s);
        @(posedge i_clk);
        act <= a;
        sin <= s;
        repeat (12) @(posedge i_clk);
    endtask : drive
    task automatic do_reset(input logic att);
        @(posedge i_clk);
        attached <= att;
        i_rst_n <= 1'b0;
        repeat (10) @(posedge i_clk);
        check({rsp.hreadyout, rsp.hresp}, 2'b10, "ready in reset");
        check({sout, sig_out}, 3'b000, "outputs in reset");
        i_rst_n <= 1'b1;
    endtask : do_reset
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        logic [31:0] rd;
        logic [15:0] rep;
        logic [15:0] val [5];
        logic ok;
        logic [1:0] s;
        logic a;
        do_reset(1'b0);
        drive(1'b0, 2'b00);
        noise <= 1'b1;
        bus(1'b0, SCS_A_CTRL, '0, rd);
        check(rd, 32'h1, "ctrl reset");
        for (int i = 0; i < 16; i++) begin
            rd = rnd();
            s = (i < 4) ? 2'(i) : rd[1:0];
            a = (i < 4) ? 1'b1 : rd[2];
            drive(a, 2'b00);
            drive(a, s);
            check(sout, exp_out(a, s), "safety out");
            check(sig_out, a, "signal out");
        end
        $display("test truth table done");
        // Start from both inputs high so the pulse below is a real dropout
        drive(1'b1, 2'b11);
        @(posedge i_clk);
        sin <= 2'b10;
        @(posedge i_clk);
        sin <= 2'b11;
        repeat (12) @(posedge i_clk);
        check(sout, 2'b11, "glitch passed");
        bus(1'b0, SCS_A_STATUS, '0, rd);
        check(rd, 32'h1F, "status after glitch");
        $display("test filter done");
        for (int k = 0; k < 2; k++) begin
            s = 2'b11 & ~(2'b01 << k);
            drive(1'b1, 2'b11);
            drive(1'b1, s);
            check(sout, s, "unequal out");
            check(ind, {SCS_IN_QUICK, SCS_DEV_RED_FLASH}, "unequal ind");
            bus(1'b0, SCS_A_STATUS, '0, rd);
            check(rd[6:5], 2'b01, "unequal flag");
            drive(1'b1, 2'b11);
            check(sout, s, "locked out");
            check(ind, {SCS_IN_FLASH, SCS_DEV_RED_FLASH}, "lock ind");
            bus(1'b0, SCS_A_STATUS, '0, rd);
            check(rd[6:5], 2'b10, "lock flag");
            drive(1'b1, 2'b00);
            drive(1'b1, 2'b11);
            check(sout, 2'b11, "lock released");
            check(ind, {SCS_IN_ON, SCS_DEV_GREEN}, "normal ind");
        end
        $display("test plausibility done");
        // With the enable low nothing may move, whatever the inputs do
        ce <= 1'b0;
        drive(1'b1, 2'b00);
        check(sout, 2'b11, "frozen out");
        ce <= 1'b1;
        drive(1'b1, 2'b00);
        check(sout, 2'b00, "thawed out");
        $display("test clock enable done");
        noise <= 1'b0;
        do_reset(1'b1);
        drive(1'b1, 2'b11);
        val[0] = 16'h019F;
        val[4] = 16'h019F;
        for (int j = 1; j < 4; j++) begin
            rd = rnd();
            val[j] = rd[15:0];
            bus(1'b1, 8'(4 * j + 4), {16'h0, val[j]}, rd);
        end
        bus(1'b0, SCS_A_SERIAL, '0, rd);
        check(rd, 32'h0, "write-only read");
        bus(1'b0, 8'h20, '0, rd);
        check(rd, 32'h0, "unmapped read");
        bus(1'b0, SCS_A_STATUS, '0, rd);
        check(rd, 32'h019F, "status diag");
        for (int j = 0; j < 5; j++) begin
            // An unassigned code must fall back to the status word
            i_scs_diag_partner.request((j < 4) ? 4'(j) : 4'hF, rep, ok);
            check(ok, 1'b1, "reply framing");
            check(rep, val[j], "reply data");
        end
        bus(1'b0, SCS_A_STATUS, '0, rd);
        check(rd[23:16], 8'h01, "action count");
        bus(1'b1, SCS_A_CTRL, 32'h0, rd);
        bus(1'b0, SCS_A_CTRL, '0, rd);
        check(rd, 32'h0, "ctrl write");
        bus(1'b0, SCS_A_STATUS, '0, rd);
        check(rd, 32'h0001011F, "status diag off");
        check(sout, 2'b11, "safety out diag off");
        $display("test diagnostics done");
        final_report();
    end
    initial begin
        repeat (30000) @(posedge i_clk);
        n_errors++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        final_report();
    end
endmodule : safety_switch_channel_logic_tb_top

// ### verif/scs_diag_partner.sv
// Behavioural diagnostic fieldbus module beside the switch.
// Assumes the bench calls request() from one process at a time.
module scs_diag_partner #(
    parameter int BIT_CYC = 10
) (
    // Clock and bench control
    input wire logic i_clk,
    input wire logic i_attached,
    input wire logic i_noise,
    // Diagnostic lines
    input wire logic i_tx_line,
    output logic o_rx_line
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv = 1'b1;
    logic tog = 1'b0;
    always @(posedge i_clk) tog <= ~tog;
    // Detached line sits at its pull-down; noise shows it is ignored
    assign o_rx_line = i_attached ? drv : (i_noise & tog);
    // One module serves a chain of up to sixteen sensors; one is modelled
    task automatic request(input logic [3:0] cmd, output logic [15:0] rep,
                           output logic ok);
        logic [17:0] frame;
        int n;
        frame = '0;
        n = 0;
        fork
            begin
                @(posedge i_clk);
                drv <= 1'b0;
                repeat (BIT_CYC) @(posedge i_clk);
                for (int i = 0; i < 4; i++) begin
                    drv <= cmd[i];
                    repeat (BIT_CYC) @(posedge i_clk);
                end
                drv <= 1'b1;
            end
            begin
                while (i_tx_line !== 1'b0 && n < 400) begin
                    @(posedge i_clk);
                    n++;
                end
                // Sample mid-bit so a small phase error does not matter
                repeat (BIT_CYC / 2) @(posedge i_clk);
                for (int i = 0; i < 18; i++) begin
                    frame[i] = i_tx_line;
                    repeat (BIT_CYC) @(posedge i_clk);
                end
            end
        join
        rep = frame[16:1];
        ok = (n < 400) && (frame[0] === 1'b0) && (frame[17] === 1'b1);
    endtask : request
endmodule : scs_diag_partner
